// >>> design/mrp_defines.svh
// register map, field positions, reset values and timing constants for the mii/rmii phy port
`ifndef MRP_DEFINES_SVH
`define MRP_DEFINES_SVH

// register offsets
`define MRP_ADDR_CTRL 4'h0
`define MRP_ADDR_STATUS 4'h1
`define MRP_ADDR_MASK 4'h2
`define MRP_ADDR_RXDATA 4'h3
`define MRP_ADDR_TXDATA 4'h4
`define MRP_ADDR_TXLAST 4'h5
`define MRP_ADDR_STATE 4'h6

// control fields and reset value (100 Mbps, full duplex)
`define MRP_CTRL_SPEED 0
`define MRP_CTRL_FDX 1
`define MRP_CTRL_RST 8'h03

// event bits, shared by status and mask
`define MRP_EVT_W 5
`define MRP_EVT_RXBYTE 0
`define MRP_EVT_RXGOOD 1
`define MRP_EVT_RXBAD 2
`define MRP_EVT_COL 3
`define MRP_EVT_TXDONE 4
`define MRP_EVT_ZERO 5'h00

// frame framing bytes
`define MRP_PRE_BYTE 8'h55
`define MRP_SFD_BYTE 8'hd5
`define MRP_PRE_LAST 3'h6
`define MRP_SFD_IDX 3'h7

// link rates; the slow rate is a tenth of the fast one
`define MRP_FAST_HZ 32'h017d7840
`define MRP_SLOW_HZ 32'h002625a0
`define MRP_SLOW_RATIO (`MRP_FAST_HZ / `MRP_SLOW_HZ)

// units per byte, as last index
`define MRP_MII_LAST 2'h1
`define MRP_RMII_LAST 2'h3

`endif

// >>> design/mrp_edge_det.sv
// two-stage synchroniser and rising edge finder for a link clock pin
`timescale 1ns/1ps
module mrp_edge_det (
  input wire logic sys_clk, // system clock
  input wire logic srst, // sync reset, high
  input wire logic pin, // raw clock pin
  mrp_edge_if.src edge_o // rising edge pulse
);
  logic [2:0] sh_q;

  // stage 0 feeds only stage 1; edge taken from stages 1 and 2
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= {sh_q[1:0], pin};
    end
  end

  // combinational so it lines up with data synchronised to the same depth
  assign edge_o.rise = sh_q[1] & ~sh_q[2];
endmodule

// >>> design/mrp_edge_if.sv
// carries a sampled link clock edge between the detector and the port
`timescale 1ns/1ps
interface mrp_edge_if;
  logic rise;
  modport src (output rise);
  modport dst (input rise);
endinterface

// >>> design/mrp_mii_port.sv
// mii/rmii phy-facing port of the mac: receive assembly, transmit framing, dce clocks, registers
`timescale 1ns/1ps
`include "mrp_defines.svh"
module mrp_mii_port (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic srst, // sync reset, high
  input wire logic [3:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [7:0] rdata, // read data, cycle after strobe
  output logic irq, // level interrupt, high
  input wire logic ref_clk, // reference clock pin
  input wire logic rx_clk_in, // receive clock pin in
  output logic rx_clk_out, // receive clock pin out
  output logic rx_clk_oe, // receive clock drive enable
  input wire logic tx_clk_in, // transmit clock pin in
  output logic tx_clk_out, // transmit clock pin out
  output logic tx_clk_oe, // transmit clock drive enable
  input wire logic collision_in, // collision from phy
  input wire logic receive_carrier_sense, // carrier sense / data valid
  input wire logic rx_data_valid, // mii receive data valid
  input wire logic rx_error, // receive error
  input wire logic [3:0] rxd, // receive data
  output logic [3:0] txd, // transmit data
  output logic tx_en, // transmit enable
  input wire logic link_role_select, // high dce, low dte
  input wire logic reduced_interface_select // high rmii, low mii
);
  mrp_edge_if ref_e();
  mrp_edge_if rxc_e();
  mrp_edge_if txc_e();

  mrp_edge_det u_ref_edge (.sys_clk(sys_clk), .srst(srst), .pin(ref_clk), .edge_o(ref_e));
  mrp_edge_det u_rxc_edge (.sys_clk(sys_clk), .srst(srst), .pin(rx_clk_in), .edge_o(rxc_e));
  mrp_edge_det u_txc_edge (.sys_clk(sys_clk), .srst(srst), .pin(tx_clk_in), .edge_o(txc_e));

  // pin synchronisers; depth matches the clock edge finders
  logic [9:0] in_s1_q;
  logic [9:0] in_s2_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_s1_q <= 10'h000;
      in_s2_q <= 10'h000;
    end else begin
      in_s1_q <= {reduced_interface_select, link_role_select, collision_in, receive_carrier_sense,
                  rx_data_valid, rx_error, rxd};
      in_s2_q <= in_s1_q;
    end
  end

  wire [3:0] rxd_w = in_s2_q[3:0];
  wire rx_err_w = in_s2_q[4];
  wire rx_dv_w = in_s2_q[5];
  wire crs_w = in_s2_q[6];
  wire col_w = in_s2_q[7];
  wire rmii_w = in_s2_q[9]; // pin only, nothing in software can change it
  wire dce_w = in_s2_q[8] & ~rmii_w; // dce has no meaning in rmii

  // control and interrupt registers
  logic [7:0] ctrl_q;
  logic [`MRP_EVT_W-1:0] status_q;
  logic [`MRP_EVT_W-1:0] mask_q;
  logic [7:0] rx_data_q;
  logic [7:0] rdata_q;
  logic irq_q;
  wire speed_w = ctrl_q[`MRP_CTRL_SPEED];
  wire fdx_w = ctrl_q[`MRP_CTRL_FDX];

  // reference divider: one tick per ref edge when fast, one per ten when slow
  localparam logic [3:0] DIV_LAST = 4'(`MRP_SLOW_RATIO - 1);
  logic [3:0] div_q;
  logic gen_q;
  wire ref_rise_w = ref_e.rise;
  wire slow_tick_w = ref_rise_w & (div_q == 4'h0);
  wire gen_tick_w = speed_w ? ref_rise_w : slow_tick_w;
  wire gen_rise_w = gen_tick_w & ~gen_q & dce_w;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q <= 4'h0;
    end else if (ref_rise_w) begin
      div_q <= (div_q == DIV_LAST) ? 4'h0 : div_q + 4'h1;
    end
  end

  // dce clock: ref/2 fast, ref/20 slow, giving 25 or 2.5 MHz from 50 MHz
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gen_q <= 1'b0;
    end else if (!dce_w) begin
      gen_q <= 1'b0;
    end else if (gen_tick_w) begin
      gen_q <= ~gen_q;
    end
  end

  // clock pins: driven only in dce mii, inputs from the phy otherwise
  logic clk_oe_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_oe_q <= 1'b0;
    end else begin
      clk_oe_q <= dce_w;
    end
  end
  assign rx_clk_out = gen_q;
  assign tx_clk_out = gen_q;
  assign rx_clk_oe = clk_oe_q;
  assign tx_clk_oe = clk_oe_q;

  // sampling events; rmii slow uses every tenth ref edge for both paths
  wire rx_evt_w = rmii_w ? gen_tick_w : (dce_w ? gen_rise_w : rxc_e.rise);
  wire tx_evt_w = rmii_w ? gen_tick_w : (dce_w ? gen_rise_w : txc_e.rise);
  wire [1:0] ulast_w = rmii_w ? `MRP_RMII_LAST : `MRP_MII_LAST;

  // receive assembly, first unit lands in the low bits
  logic [7:0] rx_sh_q;
  logic [1:0] rx_cnt_q;
  logic rx_active_q;
  logic rx_bad_q;
  wire rx_valid_w = rmii_w ? crs_w : rx_dv_w;
  wire rx_err_ok_w = rx_err_w & crs_w;
  wire [7:0] rx_asm_w = rmii_w ? {rxd_w[1:0], rx_sh_q[7:2]} : {rxd_w, rx_sh_q[7:4]};
  wire rx_take_w = rx_evt_w & rx_valid_w;
  wire rx_end_w = rx_evt_w & ~rx_valid_w & rx_active_q;
  wire rx_bad_now_w = rx_bad_q | (rx_evt_w & rx_err_ok_w);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_sh_q <= 8'h00;
      rx_cnt_q <= 2'h0;
      rx_active_q <= 1'b0;
      rx_bad_q <= 1'b0;
    end else if (rx_take_w) begin
      rx_sh_q <= rx_asm_w;
      rx_cnt_q <= (rx_cnt_q == ulast_w) ? 2'h0 : rx_cnt_q + 2'h1;
      rx_active_q <= 1'b1;
      rx_bad_q <= rx_bad_now_w;
    end else if (rx_end_w) begin
      rx_cnt_q <= 2'h0;
      rx_active_q <= 1'b0;
      rx_bad_q <= 1'b0;
    end
  end

  wire rx_byte_evt_w = rx_take_w & (rx_cnt_q == ulast_w);
  wire rx_good_evt_w = rx_end_w & ~rx_bad_now_w;
  wire rx_bad_evt_w = rx_end_w & rx_bad_now_w; // frame errored while carrier sense is high never reported good

  // transmit holding register, one byte deep
  logic [7:0] hold_q;
  logic hold_last_q;
  logic hold_v_q;
  wire tx_wr_w = wr_en & ((addr == `MRP_ADDR_TXDATA) | (addr == `MRP_ADDR_TXLAST));

  // transmit framer state
  mrp_pkg::mrp_tx_state_e tx_state_q;
  mrp_pkg::mrp_tx_state_e tx_state_d;
  logic [7:0] cur_q;
  logic [7:0] cur_d;
  logic [1:0] ucnt_q;
  logic [1:0] ucnt_d;
  logic [2:0] bcnt_q;
  logic [2:0] bcnt_d;
  logic last_q;
  logic last_d;
  logic [3:0] txd_q;
  logic [3:0] txd_d;
  logic tx_en_q;
  logic tx_en_d;
  logic take_w;
  logic tx_done_w;
  wire tx_active_w = tx_state_q != mrp_pkg::MRP_TX_IDLE;
  wire col_evt_w = tx_active_w & ~fdx_w & col_w; // full duplex ignores collision
  wire tx_defer_w = ~fdx_w & col_w; // half duplex holds a start off until the collision clears
  wire [3:0] unit_w = rmii_w ? {2'h0, cur_q[{ucnt_q, 1'b0} +: 2]} : cur_q[{ucnt_q[0], 2'h0} +: 4];

  // next unit, next byte and frame end; a half-duplex collision aborts the frame at once
  always_comb begin
    tx_state_d = tx_state_q;
    cur_d = cur_q;
    ucnt_d = ucnt_q;
    bcnt_d = bcnt_q;
    last_d = last_q;
    txd_d = txd_q;
    tx_en_d = tx_en_q;
    take_w = 1'b0;
    tx_done_w = 1'b0;
    if (col_evt_w) begin
      tx_state_d = mrp_pkg::MRP_TX_IDLE;
      tx_en_d = 1'b0;
      txd_d = 4'h0;
      cur_d = `MRP_PRE_BYTE;
      ucnt_d = 2'h0;
    end else if (tx_evt_w) begin
      case (tx_state_q)
        mrp_pkg::MRP_TX_IDLE: begin
          if (hold_v_q && !tx_defer_w) begin
            tx_en_d = 1'b1; // rises with the first preamble unit
            txd_d = unit_w;
            ucnt_d = ucnt_q + 2'h1;
            bcnt_d = 3'h0;
            tx_state_d = mrp_pkg::MRP_TX_PRE;
          end
        end
        mrp_pkg::MRP_TX_PRE, mrp_pkg::MRP_TX_DATA: begin
          txd_d = unit_w; // changes only on a transmit event (tx clock rise in mii, ref tick in rmii) or a collision abort
          if (ucnt_q != ulast_w) begin
            ucnt_d = ucnt_q + 2'h1;
          end else begin
            ucnt_d = 2'h0;
            if (tx_state_q == mrp_pkg::MRP_TX_PRE && bcnt_q != `MRP_SFD_IDX) begin
              cur_d = (bcnt_q == `MRP_PRE_LAST) ? `MRP_SFD_BYTE : `MRP_PRE_BYTE;
              bcnt_d = bcnt_q + 3'h1;
            end else if (tx_state_q == mrp_pkg::MRP_TX_DATA && last_q) begin
              tx_state_d = mrp_pkg::MRP_TX_END;
            end else if (hold_v_q) begin
              cur_d = hold_q;
              last_d = hold_last_q;
              take_w = 1'b1;
              tx_state_d = mrp_pkg::MRP_TX_DATA;
            end else begin
              tx_state_d = mrp_pkg::MRP_TX_END; // underrun cuts the frame short
            end
          end
        end
        mrp_pkg::MRP_TX_END: begin
          tx_en_d = 1'b0; // drops a full unit before any next frame
          txd_d = 4'h0;
          cur_d = `MRP_PRE_BYTE;
          tx_state_d = mrp_pkg::MRP_TX_IDLE;
          tx_done_w = 1'b1;
        end
        default: begin
          tx_state_d = mrp_pkg::MRP_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_state_q <= mrp_pkg::MRP_TX_IDLE;
      cur_q <= `MRP_PRE_BYTE;
      ucnt_q <= 2'h0;
      bcnt_q <= 3'h0;
      last_q <= 1'b0;
      txd_q <= 4'h0;
      tx_en_q <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      cur_q <= cur_d;
      ucnt_q <= ucnt_d;
      bcnt_q <= bcnt_d;
      last_q <= last_d;
      txd_q <= txd_d;
      tx_en_q <= tx_en_d;
    end
  end
  assign txd = txd_q;
  assign tx_en = tx_en_q;

  // a write in the same cycle as the framer takes the byte keeps the new one pending
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_q <= 8'h00;
      hold_last_q <= 1'b0;
      hold_v_q <= 1'b0;
    end else if (tx_wr_w) begin
      hold_q <= wdata;
      hold_last_q <= addr == `MRP_ADDR_TXLAST;
      hold_v_q <= 1'b1;
    end else if (take_w) begin
      hold_v_q <= 1'b0;
    end
  end

  // event vector; set beats a write-one clear in the same cycle
  logic [`MRP_EVT_W-1:0] evt_w;
  always_comb begin
    evt_w = `MRP_EVT_ZERO;
    evt_w[`MRP_EVT_RXBYTE] = rx_byte_evt_w;
    evt_w[`MRP_EVT_RXGOOD] = rx_good_evt_w;
    evt_w[`MRP_EVT_RXBAD] = rx_bad_evt_w;
    evt_w[`MRP_EVT_COL] = col_evt_w;
    evt_w[`MRP_EVT_TXDONE] = tx_done_w;
  end
  wire [`MRP_EVT_W-1:0] clr_w = (wr_en && addr == `MRP_ADDR_STATUS) ? wdata[`MRP_EVT_W-1:0] : `MRP_EVT_ZERO;

  // software registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= `MRP_CTRL_RST;
      mask_q <= `MRP_EVT_ZERO;
      status_q <= `MRP_EVT_ZERO;
      rx_data_q <= 8'h00;
    end else begin
      if (wr_en && addr == `MRP_ADDR_CTRL) begin
        ctrl_q <= wdata;
      end
      if (wr_en && addr == `MRP_ADDR_MASK) begin
        mask_q <= wdata[`MRP_EVT_W-1:0];
      end
      status_q <= (status_q & ~clr_w) | evt_w;
      if (rx_byte_evt_w) begin
        rx_data_q <= rx_asm_w;
      end
    end
  end

  // read decode; unmapped addresses read zero
  logic [7:0] rd_mux_w;
  always_comb begin
    if (addr == `MRP_ADDR_CTRL) begin
      rd_mux_w = ctrl_q;
    end else if (addr == `MRP_ADDR_STATUS) begin
      rd_mux_w = {3'h0, status_q};
    end else if (addr == `MRP_ADDR_MASK) begin
      rd_mux_w = {3'h0, mask_q};
    end else if (addr == `MRP_ADDR_RXDATA) begin
      rd_mux_w = rx_data_q;
    end else if (addr == `MRP_ADDR_STATE) begin
      rd_mux_w = {3'h0, dce_w, rmii_w, rx_active_q, tx_active_w, ~hold_v_q};
    end else begin
      rd_mux_w = 8'h00;
    end
  end

  // read data holds for exactly one cycle, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= rd_en ? rd_mux_w : 8'h00;
      irq_q <= |(status_q & mask_q);
    end
  end
  assign rdata = rdata_q;
  assign irq = irq_q;
endmodule

// >>> design/mrp_pkg.sv
// types shared by the phy port modules
package mrp_pkg;
  typedef enum logic [1:0] {
    MRP_TX_IDLE = 2'b00,
    MRP_TX_PRE = 2'b01,
    MRP_TX_DATA = 2'b10,
    MRP_TX_END = 2'b11
  } mrp_tx_state_e;
endpackage

// >>> tb/mrp_mii_port_sva.sv
// pin-level assertions for the phy port
`timescale 1ns/1ps
module mrp_mii_port_sva (
  input wire logic sys_clk, // clock
  input wire logic srst, // reset
  input wire logic rd_en, // read strobe
  input wire logic [7:0] rdata, // read data
  input wire logic rx_clk_out, // rx clock out
  input wire logic rx_clk_oe, // rx clock enable
  input wire logic tx_clk_out, // tx clock out
  input wire logic tx_clk_oe, // tx clock enable
  input wire logic tx_clk_in, // tx clock pin
  input wire logic [3:0] txd, // tx data
  input wire logic tx_en, // tx enable
  input wire logic link_role_select, // role strap
  input wire logic reduced_interface_select // type strap
);
  // straps only move under reset, so one domain covers everything
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_read_quiet: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("read data outside its slot");
  a_oe_pair: assert property (rx_clk_oe == tx_clk_oe) else $error("clock enables differ");
  a_clk_pair: assert property (rx_clk_out == tx_clk_out) else $error("generated clocks differ");
  a_clk_quiet: assert property (!rx_clk_oe |-> !rx_clk_out && !tx_clk_out) else $error("clock out while undriven");
  a_dce_drive: assert property ((link_role_select && !reduced_interface_select) [*8] |-> rx_clk_oe)
    else $error("dce clocks not driven");
  a_rmii_no_dce: assert property (reduced_interface_select [*8] |-> !rx_clk_oe) else $error("clocks driven in rmii");
  a_dce_toggle: assert property (rx_clk_oe |-> ##[1:900] $changed(rx_clk_out)) else $error("dce clock stuck");
  a_idle_txd: assert property (!tx_en |-> txd == 4'h0) else $error("txd busy while idle");
  a_tx_first: assert property ($rose(tx_en) |-> txd == (reduced_interface_select ? 4'h1 : 4'h5))
    else $error("frame not opened with preamble");
  a_rmii_upper: assert property (reduced_interface_select |-> txd[3:2] == 2'h0) else $error("upper txd in rmii");
  a_tx_timed: assert property ($rose(tx_en) && !reduced_interface_select && !link_role_select |-> $past(tx_clk_in, 2))
    else $error("enable not timed by tx clock");
endmodule
bind mrp_mii_port mrp_mii_port_sva i_mrp_mii_port_sva (.sys_clk, .srst, .rd_en, .rdata, .rx_clk_out, .rx_clk_oe,
  .tx_clk_out, .tx_clk_oe, .tx_clk_in, .txd, .tx_en, .link_role_select, .reduced_interface_select);

// >>> tb/mrp_phy_model.sv
// far-end phy model: link clocks, receive frames, transmit capture
`timescale 1ns/1ps
module mrp_phy_model (
  output logic rx_clk, // receive clock
  output logic tx_clk, // transmit clock
  output logic ref_clk, // reference clock
  output logic receive_carrier_sense, // carrier sense
  output logic rx_data_valid, // data valid
  output logic rx_error, // receive error
  output logic [3:0] rxd, // receive data
  input wire logic [3:0] txd, // transmit data
  input wire logic tx_en, // transmit enable
  input wire logic rmii, // reduced mode
  input wire logic slow // rmii 10 mbps
);
  logic [3:0] tx_q[$];
  wire logic drv_clk;
  assign drv_clk = rmii ? ref_clk : rx_clk;
  // clocks scaled to 5 mhz, phases unrelated to each other
  initial begin
    {receive_carrier_sense, rx_data_valid, rx_error, rxd} = 7'h00;
    rx_clk = 1'b0;
    forever #100 rx_clk = ~rx_clk;
  end
  initial begin
    tx_clk = 1'b0;
    #37;
    forever #100 tx_clk = ~tx_clk;
  end
  initial begin
    ref_clk = 1'b0;
    #61;
    forever #100 ref_clk = ~ref_clk;
  end
  // collect units the device sends; rmii units are timed by the reference clock
  wire logic cap_clk;
  assign cap_clk = rmii ? ref_clk : tx_clk;
  always @(posedge cap_clk) if (tx_en) tx_q.push_back(txd);
  // units change on falling edges so they are steady at the rise
  task automatic rx_frame(input logic [15:0] w, input int nb, input logic err, input logic crs);
    int per;
    int hold;
    per = rmii ? 2 : 4;
    hold = (rmii && slow) ? 10 : 1;
    for (int i = 0; i < nb * 8 / per; i++) begin
      repeat (hold) @(negedge drv_clk);
      rx_data_valid = 1'b1;
      receive_carrier_sense = crs;
      rx_error = err && i == 1;
      rxd = 4'((w >> (i * per)) & (rmii ? 16'h0003 : 16'h000f));
    end
    repeat (hold) @(negedge drv_clk);
    {receive_carrier_sense, rx_data_valid, rx_error} = 3'h0;
    rxd = ~rxd; // released lines keep no stale data
    repeat (2 * hold) @(posedge drv_clk);
  endtask
endmodule

// >>> tb/test_mrp_mii_port.sv
// self-checking bench for the mii/rmii phy port
`timescale 1ns/1ps
`include "mrp_defines.svh"
module test_mrp_mii_port;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic collision_in = 1'b0;
  logic link_role_select = 1'b0;
  logic reduced_interface_select = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic [3:0] txd, rxd;
  logic irq, rx_clk_out, rx_clk_oe, tx_clk_out, tx_clk_oe, tx_en, ref_clk, phy_rx_clk, phy_tx_clk;
  logic receive_carrier_sense, rx_data_valid, rx_error;
  wire logic rx_clk_w, tx_clk_w;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  // clock pins: device drives them while enabled, else the phy
  assign rx_clk_w = (rx_clk_oe === 1'b1) ? rx_clk_out : phy_rx_clk;
  assign tx_clk_w = (tx_clk_oe === 1'b1) ? tx_clk_out : phy_tx_clk;
  mrp_mii_port i_mrp_mii_port (.sys_clk, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq, .ref_clk,
    .rx_clk_in(rx_clk_w), .rx_clk_out, .rx_clk_oe, .tx_clk_in(tx_clk_w), .tx_clk_out, .tx_clk_oe, .collision_in,
    .receive_carrier_sense, .rx_data_valid, .rx_error, .rxd, .txd, .tx_en, .link_role_select,
    .reduced_interface_select);
  mrp_phy_model i_mrp_phy_model (.rx_clk(phy_rx_clk), .tx_clk(phy_tx_clk), .ref_clk, .receive_carrier_sense,
    .rx_data_valid, .rx_error, .rxd, .txd, .tx_en, .rmii(reduced_interface_select), .slow);
  // 40 mhz system clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 50000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // polls status; slow rmii frames need the long bound
  task automatic wait_bit(input int b);
    logic [7:0] d;
    d = 8'h00;
    for (int n = 0; n < 3000 && d[b] !== 1'b1; n++) rd(`MRP_ADDR_STATUS, d);
    chk({7'h00, d[b]}, 8'h01);
  endtask
  task automatic do_reset(input logic r, input logic dce);
    @(posedge sys_clk);
    srst <= 1'b1;
    reduced_interface_select <= r;
    link_role_select <= dce;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    // straps reach the port only after its two synchroniser stages
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_regs();
    rdchk(`MRP_ADDR_CTRL, `MRP_CTRL_RST);
    rdchk(`MRP_ADDR_MASK, 8'h00);
    wr(4'hf, 8'hff);
    rdchk(4'hf, 8'h00);
    wr(`MRP_ADDR_RXDATA, 8'h5a);
    rdchk(`MRP_ADDR_RXDATA, 8'h00);
    rdchk(`MRP_ADDR_STATE, 8'h01);
  endtask
  task automatic t_rx_mii();
    i_mrp_phy_model.rx_frame(16'h3c5a, 2, 1'b0, 1'b1);
    rdchk(`MRP_ADDR_RXDATA, 8'h3c);
    rdchk(`MRP_ADDR_STATUS, 8'h03);
    wr(`MRP_ADDR_STATUS, 8'hff);
    repeat (40) @(posedge sys_clk);
    rdchk(`MRP_ADDR_STATUS, 8'h00);
    i_mrp_phy_model.rx_frame(16'h00a5, 1, 1'b1, 1'b1);
    rdchk(`MRP_ADDR_STATUS, 8'h05);
    wr(`MRP_ADDR_STATUS, 8'hff);
    i_mrp_phy_model.rx_frame(16'h0096, 1, 1'b1, 1'b0);
    rdchk(`MRP_ADDR_STATUS, 8'h03);
    rdchk(`MRP_ADDR_RXDATA, 8'h96);
  endtask
  task automatic t_irq();
    wr(`MRP_ADDR_MASK, 8'h02);
    repeat (3) @(posedge sys_clk);
    #1 chk({7'h00, irq}, 8'h01);
    wr(`MRP_ADDR_STATUS, 8'h02);
    repeat (3) @(posedge sys_clk);
    #1 chk({7'h00, irq}, 8'h00);
    wr(`MRP_ADDR_MASK, 8'h00);
    wr(`MRP_ADDR_STATUS, 8'hff);
  endtask
  task automatic t_tx();
    logic [3:0] e;
    i_mrp_phy_model.tx_q.delete();
    wr(`MRP_ADDR_TXLAST, 8'hab);
    wait_bit(`MRP_EVT_TXDONE);
    chk(8'(i_mrp_phy_model.tx_q.size()), 8'h12);
    for (int i = 0; i < 18; i++) begin
      e = (i < 15) ? 4'h5 : (i == 15) ? 4'hd : (i == 16) ? 4'hb : 4'ha;
      chk({4'h0, i_mrp_phy_model.tx_q[i]}, {4'h0, e});
    end
    wr(`MRP_ADDR_STATUS, 8'hff);
  endtask
  // collision mid-frame, half duplex then full duplex
  task automatic t_col();
    for (int f = 0; f < 2; f++) begin
      wr(`MRP_ADDR_CTRL, f ? 8'h03 : 8'h01);
      wr(`MRP_ADDR_STATUS, 8'hff);
      wr(`MRP_ADDR_TXLAST, 8'h77);
      for (int n = 0; n < 400 && tx_en !== 1'b1; n++) @(posedge sys_clk);
      repeat (8) @(posedge sys_clk);
      collision_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 chk({7'h00, tx_en}, f ? 8'h01 : 8'h00);
      @(posedge sys_clk);
      collision_in <= 1'b0;
      wait_bit(`MRP_EVT_TXDONE);
      rdchk(`MRP_ADDR_STATUS, f ? 8'h10 : 8'h18);
    end
    wr(`MRP_ADDR_STATUS, 8'hff);
  endtask
  task automatic t_dce();
    do_reset(1'b0, 1'b1);
    repeat (8) @(posedge sys_clk);
    #1 chk({6'h00, rx_clk_oe, tx_clk_oe}, 8'h03);
    rdchk(`MRP_ADDR_STATE, 8'h11);
    wr(`MRP_ADDR_TXLAST, 8'h5a);
    wait_bit(`MRP_EVT_TXDONE);
    do_reset(1'b1, 1'b1);
    repeat (8) @(posedge sys_clk);
    #1 chk({6'h00, rx_clk_oe, tx_clk_oe}, 8'h00);
  endtask
  // rmii receive and transmit at both speeds
  task automatic t_rmii();
    logic [7:0] b;
    int h;
    do_reset(1'b1, 1'b0);
    rdchk(`MRP_ADDR_STATE, 8'h09);
    for (int s = 1; s >= 0; s--) begin
      b = s ? 8'hc6 : 8'h39;
      h = s ? 1 : 10;
      wr(`MRP_ADDR_CTRL, {6'h00, 1'b1, 1'(s)});
      slow <= (s == 0);
      wr(`MRP_ADDR_STATUS, 8'hff);
      i_mrp_phy_model.rx_frame({8'h00, b}, 1, 1'b0, 1'b1);
      rdchk(`MRP_ADDR_RXDATA, b);
      rdchk(`MRP_ADDR_STATUS, 8'h03);
      i_mrp_phy_model.tx_q.delete();
      wr(`MRP_ADDR_TXLAST, 8'h3c);
      wait_bit(`MRP_EVT_TXDONE);
      // 36 dibits per frame, each seen on h reference rises
      chk(8'(i_mrp_phy_model.tx_q.size() / h), 8'h24);
      chk({4'h0, i_mrp_phy_model.tx_q[33 * h]}, 8'h03);
      chk({4'h0, i_mrp_phy_model.tx_q[34 * h - 1]}, 8'h03);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    do_reset(1'b0, 1'b0);
    t_regs();
    t_rx_mii();
    t_irq();
    t_tx();
    t_col();
    t_dce();
    t_rmii();
    conclude();
  end
endmodule
